// [inc/adcpm_pkg.sv]
package adcpm_pkg;
  // Clock and timing figures; cycle counts derive from them.
  localparam int CLK_MHZ = 200;
  localparam int CLK_PERIOD_NS = 5;
  localparam int STANDBY_N_PIN_WAKE_US = 100;
  localparam int SHDN_WAKE_MS = 13;
  localparam int STANDBY_N_PIN_WAKE_CYC = STANDBY_N_PIN_WAKE_US * CLK_MHZ;
  localparam int SHDN_WAKE_CYC = SHDN_WAKE_MS * 1000 * CLK_MHZ;
  localparam int CONV_TIME_NS = 4000;
  localparam int CONV_CYC = CONV_TIME_NS / CLK_PERIOD_NS;
  localparam int TMR_W = 22;
  localparam int CNV_W = 12;
  // Channel layout.
  localparam int NCH = 6;
  localparam int CH_W = 16;
  localparam int GRP = 3;
  localparam logic [2:0] LAST_CH = 3'h5;
  // Host strobe timing.
  localparam logic [3:0] PULSE_CYC = 4'h4;
  // Covers both three-stage synchronisers plus the device's output register.
  localparam logic [3:0] READ_LO_CYC = 4'hc;
  localparam logic [3:0] READ_HI_CYC = 4'h8;
  // Host register offsets.
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CMD = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_DATA0 = 8'h10;
  // Control fields.
  localparam int CTRL_PD = 0;
  localparam int CTRL_RANGE = 1;
  localparam int CTRL_SPLIT = 2;
  localparam int CTRL_PARSER = 3;
  localparam int CTRL_BYTESEL = 4;
  localparam logic [4:0] CTRL_RST = 5'h00;
  // Command fields.
  localparam int CMD_STA = 0;
  localparam int CMD_STB = 1;
  localparam int CMD_READ = 2;
  localparam int CMD_RST = 3;
  // Sync widths and pin reset levels.
  localparam int DEV_SYNC_W = 9;
  // Standby pin high, range low, chip select and read high: the host's idle pin levels.
  localparam logic [8:0] DEV_SYNC_RST = 9'h04c;
  localparam int HOST_SYNC_W = 18;
  typedef enum logic [2:0] {
    PW_ACTIVE = 3'h0,
    PW_STANDBY = 3'h1,
    PW_SETTLE = 3'h3,
    PW_WAITRST = 3'h7,
    PW_SHUTDOWN = 3'h2
  } adcpm_pwr_t;
  typedef enum logic [2:0] {
    HS_IDLE = 3'h0,
    HS_START = 3'h1,
    HS_RDLO = 3'h3,
    HS_RDHI = 3'h2,
    HS_RESET = 3'h4
  } adcpm_hst_t;
endpackage

// [inc/adcpm_link.sv]
`timescale 1ns/1ps
// Pins between the host controller and the converter.
interface adcpm_link;
  logic startGroupA;
  logic startGroupB;
  logic standbyPinN;
  logic rangeSelect;
  logic resetPin;
  logic csN;
  logic rdN;
  logic interfaceSelect;
  logic byteSerialSelect;
  logic busy;
  logic [15:0] parallelResultBus;
  logic busOe;
  logic firstChannelFlag;
  logic firstOe;
  modport device (
    input startGroupA, startGroupB, standbyPinN, rangeSelect, resetPin,
    input csN, rdN, interfaceSelect, byteSerialSelect,
    output busy, parallelResultBus, busOe, firstChannelFlag, firstOe
  );
  modport host (
    output startGroupA, startGroupB, standbyPinN, rangeSelect, resetPin,
    output csN, rdN, interfaceSelect, byteSerialSelect,
    input busy, parallelResultBus, busOe, firstChannelFlag, firstOe
  );
endinterface

// [rtl/adcpm_sync.sv]
`timescale 1ns/1ps
module adcpm_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } adcpm_sync_t;
  adcpm_sync_t r;
  adcpm_sync_t n;
  logic [W-1:0] qNext;

  // A bit changes only once the second and third stages agree.
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      assign qNext[i] = (r.s2[i] == r.s3[i]) ? r.s3[i] : r.q[i];
    end
  endgenerate

  // Shift chain.
  always_comb begin
    n = r;
    n.s1 = d;
    n.s2 = r.s1;
    n.s3 = r.s2;
    n.q = qNext;
  end

  // State register, frozen while the clock enable is low.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      r <= {RST, RST, RST, RST};
    end else if (ce) begin
      r <= n;
    end
  end

  assign q = r.q;
endmodule

// [rtl/adcpm_device.sv]
`timescale 1ns/1ps
//Contract
// - Standby pin low, range high: standby
// - Host requests standby: standby low, range high
// - Standby low, range low: full shutdown
// - Power-down entry acts asynchronously, any time; reference off in shutdown waits for the synchroniser
// - Shutdown also powers down reference, regulator
// - Host waits 100 us after standby exit
// - Host waits 13 ms after shutdown exit
// - Host pulses reset after shutdown recovery
// - Tied starts sample every channel together
// - Busy high during conversion, internally timed
// - Results updated, then busy falls
// - Each falling read strobe presents next channel
// - All six channels converted and sent
// - First flag high on channel one only
// - Strobes high end frame; bus released
// - Split groups need separate start strobes
// - Group A edge holds channels one-three
// - Group B edge holds channels four-six
// - Convert only after both group edges
// - Reads during busy return previous results
// - Two select pins choose read interface
module adcpm_device #(
  parameter int StbyWakeCyc = adcpm_pkg::STANDBY_N_PIN_WAKE_CYC,
  parameter int ShdnWakeCyc = adcpm_pkg::SHDN_WAKE_CYC
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic ce,
  adcpm_link.device link,
  input wire logic [95:0] channelIn,
  output logic frontEndOn,
  output logic referenceOn,
  output logic parallelMode
);
  typedef struct packed {
    adcpm_pkg::adcpm_pwr_t pwr;
    logic [adcpm_pkg::TMR_W-1:0] timer;
    logic needReset;
    logic heldA;
    logic heldB;
    logic busy;
    logic [adcpm_pkg::CNV_W-1:0] convCnt;
    logic [2:0] idx;
    logic [5:0][15:0] hold;
    logic [5:0][15:0] result;
    logic [15:0] dataOut;
    logic firstFlag;
    logic busOe;
    logic prevA;
    logic prevB;
    logic prevRd;
    logic prevCs;
    logic prevRst;
    logic feOn;
    logic refOn;
  } adcpm_dev_t;

  adcpm_dev_t r;
  adcpm_dev_t n;
  logic [8:0] pins;
  logic sA, sB, sStby, sRange, sRst, sCs, sRd, sPar, sByte;
  logic aRise, bRise, rstRise, rdFall, csFall, pdReq, parMode;

  // Every pin from the host passes the three-stage synchroniser.
  adcpm_sync #(
    .W(adcpm_pkg::DEV_SYNC_W),
    .RST(adcpm_pkg::DEV_SYNC_RST)
  ) u_sync (
    .mclk(mclk),
    .resetn(resetn),
    .ce(ce),
    .d({link.startGroupA, link.startGroupB, link.standbyPinN, link.rangeSelect,
        link.resetPin, link.csN, link.rdN, link.interfaceSelect, link.byteSerialSelect}),
    .q(pins)
  );

  // Pin decode and edge detection on the synchronised levels.
  assign {sA, sB, sStby, sRange, sRst, sCs, sRd, sPar, sByte} = pins;
  assign aRise = sA & ~r.prevA;
  assign bRise = sB & ~r.prevB;
  assign rstRise = sRst & ~r.prevRst;
  assign rdFall = ~sRd & r.prevRd;
  assign csFall = ~sCs & r.prevCs;
  assign pdReq = ~sStby;
  assign parMode = ~sPar & ~sByte;

  // Power sequencing, sampling, conversion and read-out.
  always_comb begin
    n = r;
    n.prevA = sA;
    n.prevB = sB;
    n.prevRd = sRd;
    n.prevCs = sCs;
    n.prevRst = sRst;
    unique case (r.pwr)
      adcpm_pkg::PW_ACTIVE: begin
        n.feOn = 1'b1;
        n.refOn = 1'b1;
        if (rstRise) begin
          n.heldA = 1'b0;
          n.heldB = 1'b0;
          n.busy = 1'b0;
          n.idx = 3'h0;
        end else if (!r.busy) begin
          // Group A holds channels one to three.
          if (aRise) begin
            n.hold[2:0] = channelIn[47:0];
            n.heldA = 1'b1;
          end
          // Group B holds channels four to six.
          if (bRise) begin
            n.hold[5:3] = channelIn[95:48];
            n.heldB = 1'b1;
          end
          // Conversion waits for both groups to be held.
          if (n.heldA && n.heldB) begin
            n.busy = 1'b1;
            n.convCnt = adcpm_pkg::CNV_W'(adcpm_pkg::CONV_CYC - 1);
            n.heldA = 1'b0;
            n.heldB = 1'b0;
          end
        end else if (r.convCnt == '0) begin
          n.result = r.hold;
          n.busy = 1'b0;
          n.idx = 3'h0;
        end else begin
          n.convCnt = r.convCnt - 1'b1;
        end
      end
      adcpm_pkg::PW_STANDBY: begin
        n.feOn = 1'b0;
        n.refOn = 1'b1;
        if (!pdReq) begin
          n.pwr = adcpm_pkg::PW_SETTLE;
          n.timer = adcpm_pkg::TMR_W'(StbyWakeCyc - 1);
        end
      end
      adcpm_pkg::PW_SHUTDOWN: begin
        n.feOn = 1'b0;
        n.refOn = 1'b0;
        if (!pdReq) begin
          n.pwr = adcpm_pkg::PW_SETTLE;
          n.timer = adcpm_pkg::TMR_W'(ShdnWakeCyc - 1);
          n.needReset = 1'b1;
        end
      end
      adcpm_pkg::PW_SETTLE: begin
        n.feOn = 1'b1;
        n.refOn = 1'b1;
        if (r.timer != '0) begin
          n.timer = r.timer - 1'b1;
        end else if (r.needReset) begin
          n.pwr = adcpm_pkg::PW_WAITRST;
        end else begin
          n.pwr = adcpm_pkg::PW_ACTIVE;
        end
      end
      adcpm_pkg::PW_WAITRST: begin
        // Starts stay ignored until the reset pulse arrives.
        if (rstRise) begin
          n.pwr = adcpm_pkg::PW_ACTIVE;
          n.needReset = 1'b0;
          n.idx = 3'h0;
        end
      end
      default: begin
        n.pwr = adcpm_pkg::PW_ACTIVE;
      end
    endcase
    // Power-down overrides every state and aborts any conversion.
    if (pdReq) begin
      n.pwr = sRange ? adcpm_pkg::PW_STANDBY : adcpm_pkg::PW_SHUTDOWN;
      n.busy = 1'b0;
      n.heldA = 1'b0;
      n.heldB = 1'b0;
      n.feOn = 1'b0;
      n.refOn = sRange;
    end
    // Chip select falling drives the bus in parallel mode.
    if (csFall && parMode) begin
      n.busOe = 1'b1;
    end
    // Chip select high releases bus and flag.
    if (sCs || !parMode) begin
      n.busOe = 1'b0;
    end
    // Each falling read strobe shifts out the next channel.
    if (rdFall && !sCs && parMode) begin
      n.busOe = 1'b1;
      n.dataOut = r.result[r.idx];
      n.firstFlag = (r.idx == 3'h0);
      n.idx = (r.idx == adcpm_pkg::LAST_CH) ? 3'h0 : r.idx + 3'h1;
    end
  end

  // State register, frozen while the clock enable is low.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      r <= '0;
      r.prevRd <= 1'b1;
      r.prevCs <= 1'b1;
    end else if (ce) begin
      r <= n;
    end
  end

  // The raw standby pin gates busy, bus enables and front end so power-down acts at once.
  assign link.busy = r.busy & link.standbyPinN;
  assign link.busOe = r.busOe & link.standbyPinN;
  assign link.firstOe = r.busOe & link.standbyPinN;
  assign link.parallelResultBus = r.dataOut;
  assign link.firstChannelFlag = r.firstFlag;
  assign frontEndOn = r.feOn & link.standbyPinN;
  assign referenceOn = r.refOn;
  assign parallelMode = parMode;
endmodule

// [rtl/adcpm_host.sv]
// Decided for this implementation: the plain strobed port and the address map.
`timescale 1ns/1ps
module adcpm_host #(
  parameter int StbyWakeCyc = adcpm_pkg::STANDBY_N_PIN_WAKE_CYC,
  parameter int ShdnWakeCyc = adcpm_pkg::SHDN_WAKE_CYC
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wrEn,
  input wire logic rdEn,
  output logic [31:0] rdata,
  adcpm_link.host link
);
  typedef struct packed {
    adcpm_pkg::adcpm_hst_t st;
    logic [4:0] ctrl;
    logic wasShutdown;
    logic waking;
    logic needReset;
    logic [adcpm_pkg::TMR_W-1:0] timer;
    logic [3:0] cnt;
    logic [2:0] ch;
    logic pulseA;
    logic pulseB;
    logic strobeN;
    logic rstOut;
    logic refused;
    logic frameDone;
    logic firstOk;
    logic [5:0][15:0] data;
    logic [31:0] rdata;
  } adcpm_host_t;

  adcpm_host_t r;
  adcpm_host_t n;
  logic [17:0] pins;
  logic sBusy, sFirst;
  logic [15:0] sData;
  logic cmdWr, ctrlWr, startOk, split;
  logic [2:0] dIdx;

  // Device outputs are pins and pass the synchroniser.
  adcpm_sync #(
    .W(adcpm_pkg::HOST_SYNC_W),
    .RST(18'h00000)
  ) u_sync (
    .mclk(mclk),
    .resetn(resetn),
    .ce(ce),
    .d({link.busy, link.firstChannelFlag & link.firstOe,
        link.parallelResultBus & {16{link.busOe}}}),
    .q(pins)
  );

  // Decode of pins and register strobes.
  assign {sBusy, sFirst, sData} = pins;
  assign cmdWr = wrEn && (addr == adcpm_pkg::REG_CMD);
  assign ctrlWr = wrEn && (addr == adcpm_pkg::REG_CTRL);
  assign split = r.ctrl[adcpm_pkg::CTRL_SPLIT];
  assign startOk = !r.waking && !r.needReset && !r.ctrl[adcpm_pkg::CTRL_PD];
  assign dIdx = 3'((addr - adcpm_pkg::REG_DATA0) >> 2);

  // Register port, wake timing and strobe sequencing.
  always_comb begin
    n = r;
    if (ctrlWr) begin
      n.ctrl = wdata[4:0];
      if (wdata[adcpm_pkg::CTRL_PD] && !r.ctrl[adcpm_pkg::CTRL_PD]) begin
        n.wasShutdown = !wdata[adcpm_pkg::CTRL_RANGE];
        n.waking = 1'b0;
      end
      if (!wdata[adcpm_pkg::CTRL_PD] && r.ctrl[adcpm_pkg::CTRL_PD]) begin
        n.waking = 1'b1;
        n.timer = r.wasShutdown ? adcpm_pkg::TMR_W'(ShdnWakeCyc - 1)
                                : adcpm_pkg::TMR_W'(StbyWakeCyc - 1);
        n.needReset = r.wasShutdown;
      end
    end else if (r.waking) begin
      if (r.timer == '0) begin
        n.waking = 1'b0;
      end else begin
        n.timer = r.timer - 1'b1;
      end
    end
    unique case (r.st)
      adcpm_pkg::HS_IDLE: begin
        if (cmdWr) begin
          if (wdata[adcpm_pkg::CMD_RST] && !r.ctrl[adcpm_pkg::CTRL_PD] && !r.waking) begin
            n.st = adcpm_pkg::HS_RESET;
            n.rstOut = 1'b1;
            n.cnt = adcpm_pkg::PULSE_CYC;
          end else if (wdata[adcpm_pkg::CMD_READ]) begin
            n.st = adcpm_pkg::HS_RDLO;
            n.strobeN = 1'b0;
            n.ch = 3'h0;
            n.cnt = adcpm_pkg::READ_LO_CYC;
            n.firstOk = 1'b1;
          end else if ((wdata[1:0] != 2'b00) && startOk) begin
            n.st = adcpm_pkg::HS_START;
            n.cnt = adcpm_pkg::PULSE_CYC;
            n.pulseA = split ? wdata[adcpm_pkg::CMD_STA] : 1'b1;
            n.pulseB = split ? wdata[adcpm_pkg::CMD_STB] : 1'b1;
          end else begin
            n.refused = 1'b1;
          end
        end
      end
      adcpm_pkg::HS_START, adcpm_pkg::HS_RESET: begin
        if (r.cnt == 4'h1) begin
          n.st = adcpm_pkg::HS_IDLE;
          n.pulseA = 1'b0;
          n.pulseB = 1'b0;
          n.rstOut = 1'b0;
          if (r.st == adcpm_pkg::HS_RESET) begin
            n.needReset = 1'b0;
          end
        end
        n.cnt = r.cnt - 4'h1;
      end
      adcpm_pkg::HS_RDLO: begin
        n.cnt = r.cnt - 4'h1;
        if (r.cnt == 4'h1) begin
          n.data[r.ch] = sData;
          if (sFirst != (r.ch == 3'h0)) begin
            n.firstOk = 1'b0;
          end
          n.strobeN = 1'b1;
          n.st = adcpm_pkg::HS_RDHI;
          n.cnt = adcpm_pkg::READ_HI_CYC;
        end
      end
      adcpm_pkg::HS_RDHI: begin
        n.cnt = r.cnt - 4'h1;
        if (r.cnt == 4'h1) begin
          if (r.ch == adcpm_pkg::LAST_CH) begin
            n.st = adcpm_pkg::HS_IDLE;
            n.frameDone = 1'b1;
          end else begin
            n.ch = r.ch + 3'h1;
            n.strobeN = 1'b0;
            n.st = adcpm_pkg::HS_RDLO;
            n.cnt = adcpm_pkg::READ_LO_CYC;
          end
        end
      end
      default: begin
        n.st = adcpm_pkg::HS_IDLE;
      end
    endcase
    if (cmdWr && r.st != adcpm_pkg::HS_IDLE) begin
      n.refused = 1'b1;
    end
    // Read data stands for the cycle after the read strobe only.
    n.rdata = 32'h00000000;
    if (rdEn) begin
      if (addr == adcpm_pkg::REG_CTRL) begin
        n.rdata = {27'h0000000, r.ctrl};
      end else if (addr == adcpm_pkg::REG_STATUS) begin
        n.rdata = {25'h0000000, r.firstOk, r.frameDone, r.refused, r.needReset,
                   r.waking, r.st != adcpm_pkg::HS_IDLE, sBusy};
        // Clear on read; a frame end in the same cycle wins, and refused takes cmdWr && !startOk.
        n.frameDone = n.frameDone && (r.st != adcpm_pkg::HS_IDLE);
        n.refused = cmdWr && !startOk;
      end else if (addr >= adcpm_pkg::REG_DATA0 && (addr - adcpm_pkg::REG_DATA0) < 8'h18
                   && addr[1:0] == 2'h0 && dIdx <= adcpm_pkg::LAST_CH) begin
        n.rdata = {16'h0000, r.data[dIdx]};
      end
    end
  end

  // State register, frozen while the clock enable is low.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      r <= '0;
      r.strobeN <= 1'b1;
    end else if (ce) begin
      r <= n;
    end
  end

  assign rdata = r.rdata;
  assign link.standbyPinN = ~r.ctrl[adcpm_pkg::CTRL_PD];
  assign link.rangeSelect = r.ctrl[adcpm_pkg::CTRL_RANGE];
  assign link.interfaceSelect = r.ctrl[adcpm_pkg::CTRL_PARSER];
  assign link.byteSerialSelect = r.ctrl[adcpm_pkg::CTRL_BYTESEL];
  assign link.startGroupA = r.pulseA;
  assign link.startGroupB = r.pulseB;
  assign link.resetPin = r.rstOut;
  assign link.csN = r.strobeN;
  assign link.rdN = r.strobeN;
endmodule

// [tb/adcpm_properties.sv]
`timescale 1ns/1ps
// Watches the pins between host and converter and checks their timing.
module adcpm_properties (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic startGroupA,
  input wire logic startGroupB,
  input wire logic standbyPinN,
  input wire logic csN,
  input wire logic rdN,
  input wire logic interfaceSelect,
  input wire logic byteSerialSelect,
  input wire logic busy,
  input wire logic busOe,
  input wire logic firstChannelFlag,
  input wire logic firstOe
);
  logic [11:0] busyCnt_q;
  logic sawA_q;
  logic sawB_q;

  default clocking dc @(posedge mclk);
  endclocking
  default disable iff (!resetn);

  // Counts busy cycles and remembers start strobes seen since busy was last high.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      busyCnt_q <= 12'h000;
      sawA_q <= 1'b0;
      sawB_q <= 1'b0;
    end else begin
      busyCnt_q <= busy ? busyCnt_q + 12'h001 : 12'h000;
      sawA_q <= startGroupA | (sawA_q & ~busy);
      sawB_q <= startGroupB | (sawB_q & ~busy);
    end
  end

  // Power-down pins silence the converter at once.
  a_busy_powerdown: assert property (!standbyPinN |-> !busy)
    else $error("busy high while standby pin is low");
  a_bus_powerdown: assert property (!standbyPinN |-> !busOe && !firstOe)
    else $error("bus enabled while standby pin is low");
  // A conversion lasts exactly the chosen conversion time.
  a_conv_length: assert property ($fell(busy) && standbyPinN |-> busyCnt_q == adcpm_pkg::CONV_CYC)
    else $error("conversion length differs from the chosen time");
  a_conv_bound: assert property (busy |-> busyCnt_q < adcpm_pkg::CONV_CYC)
    else $error("busy held beyond the conversion time");
  // Conversion waits for both groups and then follows promptly.
  a_conv_needs_starts: assert property ($rose(busy) |-> sawA_q && sawB_q)
    else $error("busy rose before both start strobes");
  a_start_to_busy: assert property ($rose(sawA_q && sawB_q) && !busy && standbyPinN
    |-> ##[1:10] busy)
    else $error("busy did not follow the start strobes");
  // Parallel read strobes drive the bus; raising chip select releases it.
  a_read_drives: assert property ($fell(rdN) && !csN && !interfaceSelect && !byteSerialSelect
    && standbyPinN |-> ##[1:7] busOe)
    else $error("bus not driven after a read strobe");
  a_bus_release: assert property ($rose(csN) |-> ##[1:7] !busOe && !firstOe)
    else $error("bus not released after chip select rose");
  a_flag_next: assert property ($fell(rdN) && firstChannelFlag |-> ##[1:7] !firstChannelFlag)
    else $error("first channel flag held past the next strobe");
  a_serial_quiet: assert property ($fell(rdN) && (interfaceSelect || byteSerialSelect)
    |-> !busOe [*8])
    else $error("bus driven outside parallel mode");
endmodule

// [tb/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  typedef struct packed {
    logic split;
    logic [3:0] cmd1;
    logic [95:0] v;
  } adcpm_row_t;
  logic mclk;
  logic resetn;
  logic ce;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic wrEn;
  logic rdEn;
  logic [31:0] rdata;
  logic [95:0] channelIn;
  logic frontEndOn;
  logic referenceOn;
  logic parallelMode;
  logic [95:0] expV;
  adcpm_row_t rows [3];
  int miscompares;
  int n_compared;

  // Host and converter face each other across the link; host waits carry sync margin.
  adcpm_link link();
  adcpm_host #(.StbyWakeCyc(24), .ShdnWakeCyc(48)) u_adcpm_host (
    .mclk(mclk), .resetn(resetn), .ce(ce), .addr(addr), .wdata(wdata), .wrEn(wrEn),
    .rdEn(rdEn), .rdata(rdata), .link(link)
  );
  adcpm_device #(.StbyWakeCyc(20), .ShdnWakeCyc(40)) u_adcpm_device (
    .mclk(mclk), .resetn(resetn), .ce(ce), .link(link), .channelIn(channelIn),
    .frontEndOn(frontEndOn), .referenceOn(referenceOn), .parallelMode(parallelMode)
  );
  adcpm_properties u_adcpm_properties (
    .mclk(mclk), .resetn(resetn), .startGroupA(link.startGroupA),
    .startGroupB(link.startGroupB), .standbyPinN(link.standbyPinN), .csN(link.csN),
    .rdN(link.rdN), .interfaceSelect(link.interfaceSelect),
    .byteSerialSelect(link.byteSerialSelect), .busy(link.busy), .busOe(link.busOe),
    .firstChannelFlag(link.firstChannelFlag), .firstOe(link.firstOe)
  );

  // Clock of 5 ns period.
  always #2.5 mclk = ~mclk;

  // Prints the counts and the verdict, then ends the run.
  task automatic give_verdict();
    $display("Counts: %0d compared, %0d mismatched", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Compares a value and reports a mismatch at once.
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH t=%0t got %h expected %h", $time, g, e);
    end
  endtask

  // One-cycle register write and read; read data stand in the following cycle.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wrEn <= 1'b1;
    @(posedge mclk);
    wrEn <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    rdEn <= 1'b1;
    @(posedge mclk);
    rdEn <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic rdm(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    chk(d & m, e);
  endtask

  // Polls one status bit until it reaches the wanted level, with a bound.
  task automatic waitStat(input int b, input logic val);
    logic [31:0] d;
    int i;
    for (i = 0; i < 500; i++) begin
      rd(adcpm_pkg::REG_STATUS, d);
      if (d[b] === val) break;
    end
    if (i == 500) begin
      miscompares++;
      $display("MISMATCH t=%0t status wait timed out", $time);
      give_verdict();
    end
  endtask

  // Starts a conversion; the inputs change after the first hold so groups can be told apart.
  task automatic conv(input logic [3:0] c, input logic [95:0] nv, input logic sp);
    wr(adcpm_pkg::REG_CMD, {28'h0, c});
    waitStat(1, 1'b0);
    repeat (4) @(posedge mclk);
    channelIn <= nv;
    if (sp) begin
      chk({31'h0, link.busy}, 32'h0);
      wr(adcpm_pkg::REG_CMD, {28'h0, c ^ 4'h3});
      waitStat(1, 1'b0);
    end
    waitStat(0, 1'b1);
    waitStat(0, 1'b0);
  endtask

  // Reads one frame of six words and checks each against the expected channel.
  task automatic frame(input logic [95:0] v);
    logic [31:0] d;
    wr(adcpm_pkg::REG_CMD, 32'h4);
    waitStat(1, 1'b0);
    for (int i = 0; i < 6; i++) begin
      rd(adcpm_pkg::REG_DATA0 + 8'(4 * i), d);
      chk(d, {16'h0, v[16 * i +: 16]});
    end
    rdm(adcpm_pkg::REG_STATUS, 32'h40, 32'h40);
  endtask

  // Reset, the table of conversions, then hand-written cases.
  initial begin
    mclk = 1'b0;
    resetn = 1'b0;
    ce = 1'b1;
    addr = 8'h00;
    wdata = 32'h0;
    wrEn = 1'b0;
    rdEn = 1'b0;
    channelIn = '0;
    miscompares = 0;
    n_compared = 0;
    rows[0] = '{1'b0, 4'h1, 96'h6a06_5b05_4c04_3d03_2e02_1f01};
    rows[1] = '{1'b1, 4'h1, 96'h0f60_1e50_2d40_3c30_4b20_5a10};
    rows[2] = '{1'b1, 4'h2, 96'h7711_6622_5533_4444_3355_2266};
    repeat (5) @(posedge mclk);
    resetn <= 1'b1;
    rdm(adcpm_pkg::REG_CTRL, 32'hffff_ffff, 32'(adcpm_pkg::CTRL_RST));
    rdm(adcpm_pkg::REG_STATUS, 32'h1f, 32'h0);
    rdm(8'h3c, 32'hffff_ffff, 32'h0);
    chk({31'h0, parallelMode}, 32'h1);
    $display("Test reset done");
    foreach (rows[k]) begin
      expV = rows[k].v;
      if (rows[k].split && rows[k].cmd1 == 4'h1) expV[95:48] = ~expV[95:48];
      if (rows[k].split && rows[k].cmd1 == 4'h2) expV[47:0] = ~expV[47:0];
      channelIn <= rows[k].v;
      wr(adcpm_pkg::REG_CTRL, {29'h0, rows[k].split, 2'b10});
      conv(rows[k].cmd1, ~rows[k].v, rows[k].split);
      frame(expV);
      $display("Test row %0d done", k);
    end
    // Reads during a conversion give the previous sample.
    wr(adcpm_pkg::REG_CTRL, 32'h0);
    channelIn <= 96'h1234_5678_9abc_def0_0246_8ace;
    wr(adcpm_pkg::REG_CMD, 32'h1);
    wr(adcpm_pkg::REG_CMD, 32'h1);
    rdm(adcpm_pkg::REG_STATUS, 32'h10, 32'h10);
    waitStat(1, 1'b0);
    frame(expV);
    chk({31'h0, link.busy}, 32'h1);
    waitStat(0, 1'b0);
    frame(96'h1234_5678_9abc_def0_0246_8ace);
    $display("Test stale read done");
    // Standby in mid-conversion, refused starts, then wake-up.
    wr(adcpm_pkg::REG_CMD, 32'h1);
    waitStat(0, 1'b1);
    wr(adcpm_pkg::REG_CTRL, 32'h3);
    repeat (8) @(posedge mclk);
    chk({29'h0, link.busy, referenceOn, frontEndOn}, 32'h2);
    wr(adcpm_pkg::REG_CMD, 32'h1);
    rdm(adcpm_pkg::REG_STATUS, 32'h11, 32'h10);
    wr(adcpm_pkg::REG_CTRL, 32'h2);
    wr(adcpm_pkg::REG_CMD, 32'h1);
    rdm(adcpm_pkg::REG_STATUS, 32'h14, 32'h14);
    waitStat(2, 1'b0);
    channelIn <= 96'h0c0c_0b0b_0a0a_0909_0808_0707;
    conv(4'h1, 96'h0, 1'b0);
    frame(96'h0c0c_0b0b_0a0a_0909_0808_0707);
    $display("Test standby done");
    // Shutdown, wake-up and the reset pulse it needs.
    wr(adcpm_pkg::REG_CTRL, 32'h1);
    repeat (8) @(posedge mclk);
    chk({30'h0, referenceOn, frontEndOn}, 32'h0);
    wr(adcpm_pkg::REG_CTRL, 32'h0);
    waitStat(2, 1'b0);
    wr(adcpm_pkg::REG_CMD, 32'h1);
    rdm(adcpm_pkg::REG_STATUS, 32'h18, 32'h18);
    wr(adcpm_pkg::REG_CMD, 32'h8);
    waitStat(1, 1'b0);
    rdm(adcpm_pkg::REG_STATUS, 32'h8, 32'h0);
    chk({31'h0, referenceOn}, 32'h1);
    channelIn <= 96'hf0f0_e1e1_d2d2_c3c3_b4b4_a5a5;
    conv(4'h1, 96'h0, 1'b0);
    frame(96'hf0f0_e1e1_d2d2_c3c3_b4b4_a5a5);
    $display("Test shutdown done");
    // Read frames in the other interface modes leave the bus released.
    for (int m = 1; m < 4; m++) begin
      wr(adcpm_pkg::REG_CTRL, 32'(m) << 3);
      repeat (6) @(posedge mclk);
      chk({31'h0, parallelMode}, 32'h0);
      wr(adcpm_pkg::REG_CMD, 32'h4);
      waitStat(1, 1'b0);
      rdm(adcpm_pkg::REG_STATUS, 32'h40, 32'h0);
      rdm(adcpm_pkg::REG_DATA0, 32'hffff_ffff, 32'h0);
    end
    $display("Test modes done");
    give_verdict();
  end
endmodule
